// *** design/port_pkg.sv ***
// Purpose: Shared constants and carrier types for the GPIO port pin block
// Assumes: One 8-bit port, 10 MHz system clock, Avalon-MM register access
// Notes:   Register byte offsets, field positions and reset values live here
//
// Functional notes
// - Power-down or power-save sleep clamps each pin's digital input to ground.
// - No clamp on a pin whose external interrupt request is enabled.
// - On wake, high pin with edge sense and interrupt disabled sets its flag.
// - Reset forces every pull-up off regardless of earlier settings.
// - Pull-up follows override value when overridden, else dir 0, out 1, disable 0.
// - Driver enable is off in reset, else follows direction override value when overridden, else direction bit.
// - Driven level is override value when enabled, else output-value bit.
// - Toggle override inverts the output-value bit on the pin.
// - Input enable follows override value when overridden, else sleep state decides.
// - Alternate-function input is taken before the synchronizer, after the clamp.
// - Strobes shared per port; clock, sleep and global pull-up off shared by all.
// - Global pull-up off, bit 4 of mcu_control, turns off all pull-ups whose pull-up override is not enabled.
// - Direction bit one makes an output, zero makes an input.
// - Writing one to a pin-input bit toggles the matching output-value bit.
// - Portwise pull-up off is ORed with global pull-up off.
// - Pin input passes two stages before the pin-input register reads it.
package port_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_PIN_INPUT   = 5'h00;
  localparam logic [4:0] ADDR_DIRECTION   = 5'h04;
  localparam logic [4:0] ADDR_OUTPUT      = 5'h08;
  localparam logic [4:0] ADDR_MCU_CONTROL = 5'h0C;
  localparam logic [4:0] ADDR_PORT_CTRL   = 5'h10;
  localparam logic [4:0] ADDR_IRQ_STATUS  = 5'h14;
  localparam logic [4:0] ADDR_IRQ_MASK    = 5'h18;
  localparam logic [4:0] ADDR_EXT_CFG     = 5'h1C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         PIN_COUNT            = 8;
  localparam int         GLOBAL_PULLUP_OFF_BIT = 4;
  localparam int         BROWNOUT_SLEEP_BIT    = 6;
  localparam int         BROWNOUT_UNLOCK_BIT   = 5;
  localparam int         PORTWISE_PULLUP_OFF_BIT = 0;
  localparam logic [7:0] MCU_CONTROL_MASK      = 8'h70;
  localparam logic [7:0] REG_RESET             = 8'h00;
  localparam logic [1:0] SENSE_LOW_LEVEL       = 2'h0;
  localparam logic [31:0] UNMAPPED_READ        = 32'h0000_0000;

  // Timing: system clock period and input sync delay
  localparam int CLK_PERIOD_NS   = 100;
  localparam int SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic outval_override_en;
    logic outval_override_val;
    logic out_invert_en;
    logic input_en_override_en;
    logic input_en_override_val;
  } override_type;

  typedef struct packed {
    logic drive_en;
    logic drive_val;
    logic pullup_en;
    logic input_en;
  } pad_ctrl_type;

endpackage : port_pkg

// *** design/pin_ctrl.sv ***
// Purpose: Combinational control of one port pin with alternate overrides
// Assumes: Register bits come from flip-flops on sys_clk
// Notes:   Pad output value and input clamp stay purely combinational
`timescale 1ns/1ns
module pin_ctrl (
  input  wire logic                   rst,
  input  wire logic                   direction_bit,
  input  wire logic                   output_value_bit,
  input  wire logic                   pullup_off,
  input  wire logic                   sleep_clamp,
  input  wire logic                   pad_in,
  input  wire port_pkg::override_type ovr,
  output port_pkg::pad_ctrl_type      pad,
  output logic                        alt_digital_in
);

  logic out_level;

  // ----------------------------------------------------------------
  // Pull-up, driver and value resolution
  // ----------------------------------------------------------------
  always_comb begin
    out_level = output_value_bit ^ ovr.out_invert_en;
    // Reset wins so a pull-up never shows while rst is high
    if (rst) begin
      pad.pullup_en = 1'b0;
    end else if (ovr.pullup_override_en) begin
      pad.pullup_en = ovr.pullup_override_val;
    end else begin
      pad.pullup_en = !direction_bit && output_value_bit && !pullup_off;
    end
    // Driver also off in reset: pins stay tri-stated
    pad.drive_en  = rst ? 1'b0 : (ovr.dir_override_en ? ovr.dir_override_val
                                                       : direction_bit);
    pad.drive_val = ovr.outval_override_en ? ovr.outval_override_val
                                           : out_level;
    pad.input_en  = ovr.input_en_override_en ? ovr.input_en_override_val
                                             : !sleep_clamp;
  end

  // Clamped input ahead of the synchronizer, for peripherals
  assign alt_digital_in = pad.input_en & pad_in;

endmodule : pin_ctrl

// *** design/gpio_port.sv ***
// Purpose: One 8-pin GPIO port with registers, sleep clamp and ext interrupt
// Assumes: Avalon-MM slave, 10 MHz sys_clk, async active-high rst
// Notes:   Two pins (0 and 1) carry external interrupt sense logic
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module gpio_port (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Avalon-MM slave
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // Sleep controller: high in power-down or power-save
  input  wire logic                   deep_sleep,
  // Alternate function overrides, one set per pin
  input  wire port_pkg::override_type ovr [8],
  // Pads
  input  wire logic [7:0]             pad_in,
  output logic [7:0]                  pad_out,
  output logic [7:0]                  pad_oe,
  output logic [7:0]                  pad_pullup,
  output logic [7:0]                  alt_digital_in,
  output logic                        irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] direction_q;
  logic [7:0] output_q;
  logic [7:0] mcu_control_q;
  logic [7:0] port_ctrl_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic [3:0] ext_sense_q;
  logic [7:0] sync1_q;
  logic [7:0] pin_input_q;
  logic [port_pkg::SYNC_STAGES:0] sleep_hist_q;
  logic       answered_q;
  logic [1:0] prev_in_q;
  logic [7:0] clamp;
  logic       pullup_off;
  logic       wr_en;
  logic       rd_en;
  logic [1:0] edge_event;
  logic [1:0] wake_event;
  logic [1:0] irq_set;
  logic [31:0] rd_data_d;
  logic [31:0] avs_readdata_q;

  // Writes of a word require the low byte lane
  function automatic logic lane0(input logic [3:0] be);
    lane0 = be[0];
  endfunction : lane0

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------
  assign wr_en           = avs_write && answered_q;
  assign rd_en           = avs_read && answered_q;
  assign avs_waitrequest = (avs_read || avs_write) && !answered_q;
  assign avs_readdata    = avs_readdata_q;

  // Wait-state toggler keeps reads registered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      answered_q <= 1'b0;
    end else begin
      answered_q <= (avs_read || avs_write) && !answered_q;
    end
  end

  // Shared strobe decode feeds every pin of the port
  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      direction_q   <= port_pkg::REG_RESET;
      mcu_control_q <= port_pkg::REG_RESET;
      port_ctrl_q   <= port_pkg::REG_RESET;
      irq_mask_q    <= 2'h0;
      ext_sense_q   <= 4'h0;
    end else if (wr_en && lane0(avs_byteenable)) begin
      unique case (avs_address)
        port_pkg::ADDR_DIRECTION:   direction_q <= avs_writedata[7:0];
        port_pkg::ADDR_MCU_CONTROL: begin
          mcu_control_q <= avs_writedata[7:0] & port_pkg::MCU_CONTROL_MASK;
        end
        port_pkg::ADDR_PORT_CTRL:   port_ctrl_q <= avs_writedata[7:0];
        port_pkg::ADDR_IRQ_MASK:    irq_mask_q  <= avs_writedata[1:0];
        port_pkg::ADDR_EXT_CFG:     ext_sense_q <= avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  // Output register: direct write, or toggle by writing ones to pin input
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      output_q <= port_pkg::REG_RESET;
    end else if (wr_en && lane0(avs_byteenable)) begin
      if (avs_address == port_pkg::ADDR_OUTPUT) begin
        output_q <= avs_writedata[7:0];
      end else if (avs_address == port_pkg::ADDR_PIN_INPUT) begin
        output_q <= output_q ^ avs_writedata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Input synchronizer; first stage read only by second
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_q     <= 8'h00;
      pin_input_q <= 8'h00;
    end else begin
      sync1_q     <= alt_digital_in;
      pin_input_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sleep clamp and per-pin control
  // ----------------------------------------------------------------
  // Global and portwise pull-up disables combine into one term
  assign pullup_off = mcu_control_q[port_pkg::GLOBAL_PULLUP_OFF_BIT]
                    | port_ctrl_q[port_pkg::PORTWISE_PULLUP_OFF_BIT];

  // Ext interrupt pins escape the clamp while their request is enabled
  always_comb begin
    clamp = {8{deep_sleep}};
    clamp[0] = deep_sleep && !irq_mask_q[0];
    clamp[1] = deep_sleep && !irq_mask_q[1];
  end

  for (genvar i = 0; i < port_pkg::PIN_COUNT; i++) begin : g_pin
    port_pkg::pad_ctrl_type pc;
    pin_ctrl u_pin (
      .rst              (rst),
      .direction_bit    (direction_q[i]),
      .output_value_bit (output_q[i]),
      .pullup_off       (pullup_off),
      .sleep_clamp      (clamp[i]),
      .pad_in           (pad_in[i]),
      .ovr              (ovr[i]),
      .pad              (pc),
      .alt_digital_in   (alt_digital_in[i])
    );
    assign pad_out[i]    = pc.drive_val;
    assign pad_oe[i]     = pc.drive_en;
    assign pad_pullup[i] = pc.pullup_en;
  end

  // ----------------------------------------------------------------
  // External interrupt detect on pins 0 and 1
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sleep_hist_q <= '0;
      prev_in_q    <= 2'h0;
    end else begin
      // Sleep history lags by the sync depth so the wake test reads a settled pin
      sleep_hist_q <= {sleep_hist_q[port_pkg::SYNC_STAGES-1:0], deep_sleep};
      prev_in_q <= pin_input_q[1:0];
    end
  end

  // Sense 0 is low level; others are edges. Wake with high pin counts as edge
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      edge_event[k] = (ext_sense_q[2*k +: 2] != port_pkg::SENSE_LOW_LEVEL)
                    && (pin_input_q[k] != prev_in_q[k]);
      wake_event[k] = sleep_hist_q[port_pkg::SYNC_STAGES]
                    && !sleep_hist_q[port_pkg::SYNC_STAGES-1]
                    && pin_input_q[k] && !irq_mask_q[k]
                    && (ext_sense_q[2*k +: 2] != port_pkg::SENSE_LOW_LEVEL);
      irq_set[k]    = edge_event[k] || wake_event[k];
    end
  end

  // Sticky flags; a new event beats a write-one clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status_q <= 2'h0;
    end else begin
      if (wr_en && lane0(avs_byteenable)
          && avs_address == port_pkg::ADDR_IRQ_STATUS) begin
        irq_status_q <= (irq_status_q & ~avs_writedata[1:0]) | irq_set;
      end else begin
        irq_status_q <= irq_status_q | irq_set;
      end
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Read path: registered; unmapped reads return zero
  // ----------------------------------------------------------------
  always_comb begin
    unique case (avs_address)
      port_pkg::ADDR_PIN_INPUT:   rd_data_d = {24'h00_0000, pin_input_q};
      port_pkg::ADDR_DIRECTION:   rd_data_d = {24'h00_0000, direction_q};
      port_pkg::ADDR_OUTPUT:      rd_data_d = {24'h00_0000, output_q};
      port_pkg::ADDR_MCU_CONTROL: rd_data_d = {24'h00_0000, mcu_control_q};
      port_pkg::ADDR_PORT_CTRL:   rd_data_d = {24'h00_0000, port_ctrl_q};
      port_pkg::ADDR_IRQ_STATUS:  rd_data_d = {30'h0000_0000, irq_status_q};
      port_pkg::ADDR_IRQ_MASK:    rd_data_d = {30'h0000_0000, irq_mask_q};
      port_pkg::ADDR_EXT_CFG:     rd_data_d = {28'h000_0000, ext_sense_q};
      default:                    rd_data_d = port_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avs_readdata_q <= 32'h0000_0000;
    end else if (avs_read && !answered_q) begin
      avs_readdata_q <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_pullup_off: assert property (@(posedge sys_clk) rst |-> pad_pullup == 8'h00)
    else $error("pull-up on during reset");
  a_global_pullup_off: assert property (@(posedge sys_clk) disable iff (rst)
      (mcu_control_q[port_pkg::GLOBAL_PULLUP_OFF_BIT] && !ovr[2].pullup_override_en)
      |-> !pad_pullup[2])
    else $error("pull-up on with global disable");
  a_toggle_output: assert property (@(posedge sys_clk) disable iff (rst)
      (wr_en && avs_byteenable[0] && avs_address == port_pkg::ADDR_PIN_INPUT)
      |=> output_q == ($past(output_q) ^ $past(avs_writedata[7:0])))
    else $error("pin input write did not toggle");
  a_sync_delay: assert property (@(posedge sys_clk) disable iff (rst)
      !rst |-> ##2 pin_input_q == $past(alt_digital_in, 2))
    else $error("input sync delay wrong");
  a_clamp_input: assert property (@(posedge sys_clk) disable iff (rst)
      (deep_sleep && !ovr[4].input_en_override_en) |-> !alt_digital_in[4])
    else $error("clamp not applied");
  a_driver_dir: assert property (@(posedge sys_clk) disable iff (rst)
      !ovr[3].dir_override_en |-> pad_oe[3] == direction_q[3])
    else $error("driver enable mismatch");
  a_wake_flag: assert property (@(posedge sys_clk) disable iff (rst)
      wake_event[0] |=> irq_status_q[0])
    else $error("wake flag not set");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
      irq_status_q[1] && irq_mask_q[1] |-> irq)
    else $error("irq not raised");

endmodule : gpio_port

// *** sim/pad_partner.sv ***
// Purpose: Far side of the port: pads, external drivers and pull-ups
// Assumes: The port's own driver wins over an external driver
// Notes:   Undriven lines without pull-up flip each cycle, so no stale level looks valid
`timescale 1ns/1ns
module pad_partner (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_lvl,
  output logic [7:0]      pad_in
);
  logic [7:0] float_q = 8'h55;

  // Floating lines wander instead of holding their last value
  always_ff @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  // Wire level from every party that can drive it
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_lvl[i];
      end else if (pad_pullup[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = float_q[i];
      end
    end
  end
endmodule : pad_partner

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the GPIO port
// Assumes: One wait state per bus access, as the port answers
// Notes:   Random pin setups plus sleep, wake, toggle and reset corners
`timescale 1ns/1ns
module testbench;
  logic                   sys_clk;
  logic                   rst;
  logic [4:0]             avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [3:0]             avs_byteenable;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   deep_sleep;
  port_pkg::override_type ovr [8];
  port_pkg::override_type ov [8];
  port_pkg::pad_ctrl_type p;
  logic [7:0]             pad_in, pad_out, pad_oe, pad_pullup, alt_digital_in;
  logic [7:0]             ext_en, ext_lvl, dir, out, eoe, eout, epu, r;
  logic                   irq, global_pullup_off;
  int                     miscompares, checks_done;

  gpio_port gpio_port_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .deep_sleep(deep_sleep), .ovr(ovr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .alt_digital_in(alt_digital_in), .irq(irq));
  pad_partner pad_partner_inst (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_in(pad_in));

  // Free-running 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One Avalon access; the request holds until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= 32'(d);
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) miscompares++;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check($sformatf("reg %h", a), q, exp);
  endtask : rd

  // Expected pad controls of one pin
  function automatic port_pkg::pad_ctrl_type exp_pad(logic d, logic o, logic pd,
                                                     port_pkg::override_type v);
    port_pkg::pad_ctrl_type e;
    e.drive_en  = v.dir_override_en ? v.dir_override_val : d;
    e.drive_val = v.outval_override_en ? v.outval_override_val : (o ^ v.out_invert_en);
    e.pullup_en = v.pullup_override_en ? v.pullup_override_val : (!d && o && !pd);
    e.input_en  = 1'b1;
    return e;
  endfunction : exp_pad

  task automatic set_ovr;
    for (int i = 0; i < 8; i++) ovr[i] <= ov[i];
  endtask : set_ovr

  // Watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end

  initial begin
    rst = 1'b1; avs_address = 5'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0000_0000; deep_sleep = 1'b0; ext_en = 8'h00; ext_lvl = 8'h00;
    for (int i = 0; i < 8; i++) ovr[i] = '0;
    avs_byteenable = 4'hF;
    void'($urandom(32'h21e4));
    repeat (3) @(posedge sys_clk);
    check("irq in reset", irq, 1'b0);
    rst <= 1'b0;
    rd(port_pkg::ADDR_MCU_CONTROL, 32'h0000_0000);
    // Random pin setups; the first two isolate each pull-up disable
    for (int k = 0; k < 30; k++) begin
      dir = 8'($urandom); out = 8'($urandom); global_pullup_off = 1'($urandom); r[0] = 1'($urandom);
      for (int i = 0; i < 8; i++) begin
        ov[i] = port_pkg::override_type'(9'($urandom));
        ov[i].out_invert_en = 1'b0;
        if (k < 2) ov[i] = '0;
      end
      if (k < 2) begin
        dir = 8'h00; out = 8'hFF; global_pullup_off = (k == 0); r[0] = (k == 1);
      end
      set_ovr();
      wr(port_pkg::ADDR_DIRECTION, dir);
      wr(port_pkg::ADDR_OUTPUT, out);
      wr(port_pkg::ADDR_MCU_CONTROL, 8'(global_pullup_off) << port_pkg::GLOBAL_PULLUP_OFF_BIT);
      wr(port_pkg::ADDR_PORT_CTRL, 8'(r[0]));
      @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        p = exp_pad(dir[i], out[i], global_pullup_off | r[0], ov[i]);
        eoe[i] = p.drive_en; eout[i] = p.drive_val; epu[i] = p.pullup_en;
      end
      check("pad_oe", pad_oe, eoe);
      check("pad_out", pad_out & eoe, eout & eoe);
      check("pad_pullup", pad_pullup, epu);
    end
    for (int i = 0; i < 8; i++) ov[i] = '{out_invert_en: 1'b1, default: 1'b0};
    set_ovr();
    wr(port_pkg::ADDR_DIRECTION, 8'hFF);
    wr(port_pkg::ADDR_OUTPUT, 8'h5A);
    @(posedge sys_clk);
    check("pad_out inverted", pad_out, 8'hA5);
    wr(port_pkg::ADDR_PIN_INPUT, 8'h0F);
    rd(port_pkg::ADDR_OUTPUT, 32'h0000_0055);
    wr(port_pkg::ADDR_MCU_CONTROL, 8'hFF);
    rd(port_pkg::ADDR_MCU_CONTROL, 32'(port_pkg::MCU_CONTROL_MASK));
    wr(5'h02, 8'hFF);
    rd(5'h02, port_pkg::UNMAPPED_READ);
    // A write without the low byte lane must leave the register alone
    avs_byteenable <= 4'hE;
    wr(port_pkg::ADDR_DIRECTION, 8'hAA);
    avs_byteenable <= 4'hF;
    rd(port_pkg::ADDR_DIRECTION, 32'h0000_00FF);
    // External levels reach the input path
    for (int i = 0; i < 8; i++) ov[i] = '0;
    set_ovr();
    wr(port_pkg::ADDR_MCU_CONTROL, 8'h00);
    wr(port_pkg::ADDR_DIRECTION, 8'h00);
    r = 8'($urandom);
    ext_en <= 8'hFF;
    ext_lvl <= r;
    repeat (3) @(posedge sys_clk);
    check("alt_digital_in", alt_digital_in, r);
    rd(port_pkg::ADDR_PIN_INPUT, 32'(r));
    // Sleep clamp with interrupt pin 1 and input overrides on pins 6 and 7
    ext_lvl <= 8'hFF;
    ov[7] = '{input_en_override_en: 1'b1, input_en_override_val: 1'b1, default: 1'b0};
    ov[6] = '{input_en_override_en: 1'b1, default: 1'b0};
    set_ovr();
    wr(port_pkg::ADDR_EXT_CFG, 8'h05);
    wr(port_pkg::ADDR_IRQ_MASK, 8'h02);
    repeat (4) @(posedge sys_clk);
    wr(port_pkg::ADDR_IRQ_STATUS, 8'hFF);
    check("alt_digital_in awake", alt_digital_in, 8'hBF);
    deep_sleep <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("alt_digital_in asleep", alt_digital_in, 8'h82);
    deep_sleep <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(port_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    check("irq masked", irq, 1'b0);
    wr(port_pkg::ADDR_IRQ_MASK, 8'h03);
    @(posedge sys_clk);
    check("irq unmasked", irq, 1'b1);
    wr(port_pkg::ADDR_IRQ_STATUS, 8'h01);
    rd(port_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    check("irq cleared", irq, 1'b0);
    // Reset in mid-run drops configured pull-ups
    ext_en <= 8'h00;
    // Portwise disable was left random by the pin setups
    wr(port_pkg::ADDR_PORT_CTRL, 8'h00);
    wr(port_pkg::ADDR_OUTPUT, 8'hFF);
    @(posedge sys_clk);
    check("pullups before reset", pad_pullup, 8'hFF);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("pullups in reset", pad_pullup, 8'h00);
    check("oe in reset", pad_oe, 8'h00);
    rst <= 1'b0;
    rd(port_pkg::ADDR_OUTPUT, 32'(port_pkg::REG_RESET));
    final_report();
  end
endmodule : testbench
